// [ebp_defs.vh]
`ifndef EBP_DEFS_VH
`define EBP_DEFS_VH
`define EBP_AW          32
`define EBP_DW          64
`define EBP_RATW        3
`define EBP_RAT_RSVD    3'h7
`define EBP_RAT_DEF     4'h4
`define EBP_CNTW        4
`define EBP_FIFO_DEPTH  4
`define EBP_FIFO_AW     2
`define EBP_ST_IDLE     3'h0
`define EBP_ST_ADDR     3'h1
`define EBP_ST_RDATA    3'h2
`define EBP_ST_WDATA    3'h3
`define EBP_ST_HALT     3'h4
`define EBP_DONE_DLY    4'h8
`endif

// [ebp_fifo.v]
`default_nettype none
module ebp_fifo #(
    parameter WIDTH = 64,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    input  wire             clock,
    input  wire             reset_n,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output reg  [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wr_ptr;
    reg [AW:0]      rd_ptr;
    wire [AW:0]     fill;
    wire            push;
    wire            pop;

    assign fill      = wr_ptr - rd_ptr;
    assign in_ready  = (fill != DEPTH[AW:0]);
    assign out_valid = (fill != {(AW+1){1'b0}});
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always @*
    begin
        out_data = mem[rd_ptr[AW-1:0]];
    end

    always @(posedge clock)
    begin
        if (!reset_n)
        begin
            wr_ptr <= {(AW+1){1'b0}};
            rd_ptr <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
            begin
                mem[wr_ptr[AW-1:0]] <= in_data;
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop)
                rd_ptr <= rd_ptr + 1'b1;
        end
    end
endmodule
`default_nettype wire

// [ebp_top.v]
`include "ebp_defs.vh"
`default_nettype none
module ebp_top (
    input  wire                 clock,
    input  wire                 reset_n,
    input  wire [`EBP_RATW-1:0] core_ratio_sel,
    output reg  [3:0]           core_ratio,
    output reg                  ratio_reserved,
    output reg                  core_run,
    output reg                  reset_done,
    input  wire                 release_bus,
    input  wire                 bus_master,
    input  wire                 dbg_halt_req,
    output reg                  dbg_halted,
    input  wire                 req_valid,
    output wire                 req_ready,
    input  wire                 req_write,
    input  wire                 req_sdram,
    input  wire [`EBP_AW-1:0]   req_addr,
    input  wire [`EBP_DW-1:0]   req_wdata,
    output wire [`EBP_DW-1:0]   rd_data,
    output wire                 rd_valid,
    input  wire                 rd_ready,
    input  wire [`EBP_AW-1:0]   addr_in,
    output reg  [`EBP_AW-1:0]   addr_out,
    output reg                  addr_oe,
    input  wire [`EBP_DW-1:0]   data_in,
    output reg  [`EBP_DW-1:0]   data_out,
    output reg                  data_oe,
    input  wire                 rd_n_in,
    output reg                  rd_n_out,
    output reg                  rd_n_oe,
    output reg                  slv_read,
    output reg  [`EBP_AW-1:0]   slv_addr
);
    reg [2:0]           state;
    reg [2:0]           next_state;
    reg                 halt_s1;
    reg                 halt_s2;
    reg                 rel_s1;
    reg                 rel_s2;
    reg [`EBP_CNTW-1:0] done_cnt;
    reg                 cur_write;
    reg [`EBP_DW-1:0]   cur_wdata;
    reg                 cap_valid;
    reg [`EBP_DW-1:0]   cap_data;
    wire                fifo_ready;

    function [3:0] ratio_of;
        input [`EBP_RATW-1:0] sel;
        begin
            case (sel)
                3'h0:    ratio_of = 4'h4;
                3'h1:    ratio_of = 4'h5;
                3'h2:    ratio_of = 4'h6;
                3'h3:    ratio_of = 4'h7;
                3'h4:    ratio_of = 4'h8;
                3'h5:    ratio_of = 4'ha;
                3'h6:    ratio_of = 4'hc;
                default: ratio_of = `EBP_RAT_DEF;
            endcase
        end
    endfunction

    // Only idle takes a request; capture stall ignores the capture in flight, so a read taken one short of full can be dropped
    assign req_ready = (state == `EBP_ST_IDLE) && bus_master
                       && !rel_s2 && !halt_s2 && reset_done && fifo_ready;

    always @*
    begin
        next_state = state;
        case (state)
            `EBP_ST_IDLE:
            begin
                if (halt_s2)
                    next_state = `EBP_ST_HALT;
                else if (req_valid && req_ready)
                    next_state = `EBP_ST_ADDR;
            end
            `EBP_ST_ADDR:
                next_state = cur_write ? `EBP_ST_WDATA : `EBP_ST_RDATA;
            `EBP_ST_RDATA:
                next_state = `EBP_ST_IDLE;
            `EBP_ST_WDATA:
                next_state = `EBP_ST_IDLE;
            `EBP_ST_HALT:
                if (!halt_s2)
                    next_state = `EBP_ST_IDLE;
            default:
                next_state = `EBP_ST_IDLE;
        endcase
    end

    always @(posedge clock)
    begin
        if (!reset_n)
        begin
            halt_s1 <= 1'b0;
            halt_s2 <= 1'b0;
            rel_s1  <= 1'b0;
            rel_s2  <= 1'b0;
        end
        else
        begin
            halt_s1 <= dbg_halt_req;
            halt_s2 <= halt_s1;
            rel_s1  <= release_bus;
            rel_s2  <= rel_s1;
        end
    end

    // Ratio is resampled on every clock after reset release; pins are held static anyway
    always @(posedge clock)
    begin
        if (!reset_n)
        begin
            core_ratio     <= `EBP_RAT_DEF;
            ratio_reserved <= 1'b0;
            done_cnt       <= {`EBP_CNTW{1'b0}};
            reset_done     <= 1'b0;
            core_run       <= 1'b0;
        end
        else
        begin
            core_ratio     <= ratio_of(core_ratio_sel);
            ratio_reserved <= (core_ratio_sel == `EBP_RAT_RSVD);
            if (done_cnt != `EBP_DONE_DLY)
                done_cnt <= done_cnt + 1'b1;
            else
                reset_done <= 1'b1;
            // One instruction slot per core clock while running
            core_run <= reset_done && (state != `EBP_ST_HALT)
                        && !ratio_reserved;
        end
    end

    always @(posedge clock)
    begin
        if (!reset_n)
        begin
            state      <= `EBP_ST_IDLE;
            dbg_halted <= 1'b0;
            addr_out   <= {`EBP_AW{1'b0}};
            addr_oe    <= 1'b0;
            data_out   <= {`EBP_DW{1'b0}};
            data_oe    <= 1'b0;
            rd_n_out   <= 1'b1;
            rd_n_oe    <= 1'b0;
            cur_write  <= 1'b0;
            cur_wdata  <= {`EBP_DW{1'b0}};
            cap_valid  <= 1'b0;
            cap_data   <= {`EBP_DW{1'b0}};
            slv_read   <= 1'b0;
            slv_addr   <= {`EBP_AW{1'b0}};
        end
        else
        begin
            state      <= next_state;
            dbg_halted <= (next_state == `EBP_ST_HALT);
            cap_valid  <= 1'b0;
            if (state == `EBP_ST_IDLE && req_valid && req_ready)
            begin
                cur_write  <= req_write;
                cur_wdata  <= req_wdata;
            end
            // Address and strobe launch from the same edge
            if (state == `EBP_ST_ADDR)
            begin
                addr_out <= addr_out;
            end
            if (state == `EBP_ST_IDLE && req_valid && req_ready)
            begin
                addr_out <= req_addr;
                addr_oe  <= 1'b1;
                rd_n_out <= !(!req_write && !req_sdram);
                rd_n_oe  <= 1'b1;
            end
            else if (next_state == `EBP_ST_IDLE
                     || next_state == `EBP_ST_HALT)
            begin
                rd_n_out <= 1'b1;
                addr_oe  <= 1'b0;
                rd_n_oe  <= 1'b0;
            end
            if (state == `EBP_ST_ADDR && cur_write)
            begin
                data_out <= cur_wdata;
                data_oe  <= 1'b1;
            end
            else
                data_oe <= 1'b0;
            if (state == `EBP_ST_RDATA)
            begin
                cap_data  <= data_in;
                cap_valid <= 1'b1;
            end
            // Slave side: sample only when another master owns the bus
            slv_read <= !bus_master && !addr_oe && !rd_n_in;
            if (!bus_master && !addr_oe && !rd_n_in)
                slv_addr <= addr_in;
            if (rel_s2)
            begin
                addr_oe <= 1'b0;
                data_oe <= 1'b0;
                rd_n_oe <= 1'b0;
            end
        end
    end

    ebp_fifo #(
        .WIDTH (`EBP_DW),
        .DEPTH (`EBP_FIFO_DEPTH),
        .AW    (`EBP_FIFO_AW)
    ) u_fifo (
        .clock     (clock),
        .reset_n   (reset_n),
        .in_data   (cap_data),
        .in_valid  (cap_valid),
        .in_ready  (fifo_ready),
        .out_data  (rd_data),
        .out_valid (rd_valid),
        .out_ready (rd_ready)
    );
endmodule
`default_nettype wire

// [ebp_chk_assertions.sv]
`default_nettype none
module ebp_chk (
    input wire logic       clock,
    input wire logic       reset_n,
    input wire logic [2:0] core_ratio_sel,
    input wire logic [3:0] core_ratio,
    input wire logic       ratio_reserved,
    input wire logic       reset_done,
    input wire logic       release_bus,
    input wire logic       req_valid,
    input wire logic       req_ready,
    input wire logic       req_write,
    input wire logic       req_sdram,
    input wire logic       addr_oe,
    input wire logic       data_oe,
    input wire logic       rd_n_out,
    input wire logic       rd_n_oe
);
    wire [4:0] ratio_exp = core_ratio_sel == 3'h7 ? 5'h14
        : core_ratio_sel == 3'h6 ? 5'h0c : core_ratio_sel == 3'h5 ? 5'h0a
        : {2'h0, core_ratio_sel} + 5'h04;
    default clocking @(posedge clock); endclocking
    sequence s_take(w);
        req_valid && req_ready && req_write == w;
    endsequence
    sequence s_off;
        !addr_oe && !data_oe && !rd_n_oe;
    endsequence
    a_reset_off: assert property (
        !reset_n |=> s_off ##0 (rd_n_out && !reset_done))
        else $error("pins driven in reset");
    a_ratio_map: assert property (disable iff (!reset_n)
        $past(reset_n) |-> {ratio_reserved, core_ratio} == $past(ratio_exp))
        else $error("wrong core ratio");
    a_read_walk: assert property (disable iff (!reset_n)
        s_take(1'b0) |=> (addr_oe && rd_n_oe && rd_n_out == $past(req_sdram))
        ##1 (addr_oe && $stable(rd_n_out)) ##1 (!addr_oe && rd_n_out))
        else $error("read strobe walk");
    a_strobe_addr: assert property (disable iff (!reset_n)
        $changed(rd_n_out) |-> $changed(addr_oe))
        else $error("strobe apart from address");
    a_write_walk: assert property (disable iff (!reset_n)
        s_take(1'b1) |=> (addr_oe && rd_n_out && !data_oe) ##1 data_oe
        ##1 s_off)
        else $error("write data phase");
    a_done_delay: assert property (disable iff (!reset_n)
        $rose(reset_n) |-> !reset_done [*8] ##1 !reset_done ##1 reset_done)
        else $error("reset done timing");
    a_release_off: assert property (disable iff (!reset_n)
        release_bus [*4] |-> s_off)
        else $error("pins driven while released");
    a_strobe_low: assert property (disable iff (!reset_n)
        !rd_n_out |-> rd_n_oe && addr_oe && !data_oe)
        else $error("strobe low while idle");
endmodule
bind ebp_top ebp_chk ebp_chk_i (.*);
`default_nettype wire

// [ebp_mem_model.sv]
`default_nettype none
module ebp_mem_model (
    input wire logic        clock,
    input wire logic [31:0] addr_out,
    input wire logic        addr_oe,
    input wire logic [63:0] data_out,
    input wire logic        data_oe,
    output logic     [63:0] data_in,
    output logic     [63:0] wr_data
);
    timeunit 1ns;
    timeprecision 1ns;
    // Undriven data lines float to the pull-up level, never the last word
    assign data_in = data_oe ? data_out
        : addr_oe ? {~addr_out, addr_out} : '1;
    always @(posedge clock)
        if (data_oe)
            wr_data <= data_out;
endmodule
`default_nettype wire

// [test_ext_bus_clock_reset_pins.sv]
`default_nettype none
module test_ext_bus_clock_reset_pins;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock, reset_n, release_bus, bus_master, dbg_halt_req;
    logic        req_valid, req_write, req_sdram, rd_ready, rd_n_in;
    logic        req_ready, rd_valid, ratio_reserved, core_run, slv_read;
    logic        reset_done, dbg_halted, addr_oe, data_oe, rd_n_out;
    logic        rd_n_oe;
    logic [2:0]  core_ratio_sel;
    logic [3:0]  core_ratio;
    logic [31:0] req_addr, addr_in, addr_out, slv_addr;
    logic [31:0] lf = 8;
    logic [63:0] req_wdata, rd_data, data_in, data_out, wr_data;
    logic [63:0] exp_q[$];
    logic [4:0]  rtab [8] = '{4, 5, 6, 7, 8, 10, 12, 20};
    int          n_mismatch = 0, checks = 0, cyc = 0;
    wire  [4:0]  pins = {rd_n_out, addr_oe, data_oe, rd_n_oe, reset_done};

    ebp_top ebp_top_i (.*);
    ebp_mem_model ebp_mem_model_i (.*);

    initial
    begin
        clock = 0;
        forever #25 clock = ~clock;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    task automatic chk(input string nm, input logic [63:0] e, g);
        checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #5;
    endtask

    task automatic req(input logic w, s, input logic [31:0] a);
        int n;
        tick(1);
        {req_valid, req_write, req_sdram, req_addr} = {1'b1, w, s, a};
        req_wdata = {a, ~a};
        for (n = 0; !req_ready && n < 40; n++)
            tick(1);
        tick(1);
        req_valid = 0;
        if (!w)
            exp_q.push_back({~a, a});
        if (w)
        begin
            tick(3);
            chk("wr_data", {a, ~a}, wr_data);
        end
    endtask

    always @(negedge clock)
        if (rd_valid && rd_ready)
            chk("rd_data", exp_q.pop_front(), rd_data);

    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_mismatch++;
            close_out;
        end
    end

    initial
    begin
        {reset_n, release_bus, dbg_halt_req, req_valid} = 0;
        {req_write, req_sdram, core_ratio_sel, req_addr, req_wdata} = 0;
        {bus_master, rd_ready, rd_n_in} = 3'h7;
        addr_in = '1;
        tick(8);
        chk("reset_pins", 5'h10, pins);
        reset_n = 1;
        tick(12);
        chk("reset_done", 1, reset_done);
        // In this sweep select pins only move while the part is held in reset; the return to 0 after it is not
        foreach (rtab[s])
        begin
            reset_n = 0;
            core_ratio_sel = 3'(s);
            tick(2);
            reset_n = 1;
            tick(12);
            chk("ratio", rtab[s], {ratio_reserved, core_ratio});
            chk("core_run", s != 7, core_run);
        end
        core_ratio_sel = 0;
        req(0, 0, '0);
        req(0, 1, '1);
        repeat (20)
        begin
            lf = lfsr(lf);
            req(lf[0], lf[1], lf);
        end
        rd_ready = 0;
        repeat (4)
        begin
            lf = lfsr(lf);
            req(0, 0, lf);
        end
        tick(4);
        chk("full_ready", 0, req_ready);
        // Random stalls while draining keep back-pressure on the FIFO
        repeat (16)
        begin
            lf = lfsr(lf);
            rd_ready = lf[0];
            tick(1);
        end
        rd_ready = 1;
        tick(4);
        chk("drained", 0, {rd_valid, exp_q.size()});
        bus_master = 0;
        lf = lfsr(lf);
        addr_in = lf;
        rd_n_in = 0;
        tick(1);
        {rd_n_in, addr_in} = '1;
        chk("slv_read", {1'b1, lf}, {slv_read, slv_addr});
        chk("slave_pins", 5'h11, pins);
        bus_master = 1;
        release_bus = 1;
        tick(4);
        chk("rel_ready", 0, req_ready);
        release_bus = 0;
        dbg_halt_req = 1;
        tick(6);
        chk("halted", 2'b10, {dbg_halted, core_run});
        dbg_halt_req = 0;
        tick(6);
        chk("resumed", 2'b01, {dbg_halted, core_run});
        reset_n = 0;
        tick(2);
        chk("mid_reset", 5'h10, pins);
        chk("idle_run", 0, core_run);
        reset_n = 1;
        tick(12);
        req(0, 0, 32'h1234_5678);
        tick(6);
        close_out;
    end
endmodule
`default_nettype wire
